// [shared/bio_frontend_pkg.sv]
// Purpose: Shared constants and types for the body-impedance front-end control bank
// Assumes: AHB-Lite slave, 32-bit data, one register per aligned word
// Notes: Byte offsets are local choices; all registers reset to zero
package bio_frontend_pkg;
   // ==========================================================
   // Register byte offsets
   localparam logic [7:0] OFS_SINE_GEN_CTRL = 8'h00;
   localparam logic [7:0] OFS_SINE_CLOCK_DIVISOR = 8'h04;
   localparam logic [7:0] OFS_HALF_WAVE_SAMPLE_COUNT = 8'h08;
   localparam logic [7:0] OFS_AMP_CTRL = 8'h0c;
   localparam logic [7:0] OFS_ELECTRODE_SWITCH_CTRL = 8'h10;
   localparam logic [7:0] OFS_AMP_REF_DAC = 8'h14;
   localparam logic [7:0] OFS_PEAK_FILTER_CTRL = 8'h18;
   localparam logic [7:0] OFS_STATUS = 8'h1c;
   // ==========================================================
   // Writable bit masks per register
   localparam logic [7:0] MASK_SINE_GEN_CTRL = 8'h90;
   localparam logic [7:0] MASK_SINE_CLOCK_DIVISOR = 8'h3f;
   localparam logic [7:0] MASK_HALF_WAVE_SAMPLE_COUNT = 8'h1f;
   localparam logic [7:0] MASK_AMP_CTRL = 8'h8f;
   localparam logic [7:0] MASK_ELECTRODE_SWITCH_CTRL = 8'hff;
   localparam logic [7:0] MASK_AMP_REF_DAC = 8'h3f;
   localparam logic [7:0] MASK_PEAK_FILTER_CTRL = 8'h83;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [3:0] GAIN_CODE_MAX = 4'ha;
   // Sine-pattern RAM window in data bank 2
   localparam logic [1:0] PATTERN_BANK = 2'h2;
   localparam logic [7:0] PATTERN_LO = 8'h40;
   localparam logic [7:0] PATTERN_HI = 8'h7f;
   localparam int NUM_REGS = 7;
   // ==========================================================
   // Decoded analogue controls
   typedef struct packed {
      logic sine_gen_on;
      logic bias_divider_on;
      logic [6:0] sine_n;
      logic [5:0] half_cycle_samples;
      logic amp_power_off;
      logic [3:0] diff_amp_gain_code;
      logic [7:0] switches;
      logic [5:0] ref_dac_code;
      logic peak_filter_on;
      logic [1:0] discharge;
   } analog_ctrl_t;
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_WRITE = 2'b01,
      BUS_READ = 2'b10
   } bus_phase_t;
endpackage

// [rtl/bio_impedance_frontend_ctrl.sv]
// Purpose: Register bank driving the body-impedance analogue front end
// Assumes: AHB-Lite single word transfers, zero wait states, OKAY only
// Notes: Analogue blocks see only enables and codes from flip-flops
// How it works
// [R1] Sine generator off powers down output amp, DAC
// [R2] Bias divider on when bit 4 set
// [R3] Unimplemented bits read zero, ignore writes
// [R4] Divisor N equals field plus one
// [R5] Half-cycle samples equal field plus one
// [R6] Amp bit 7 high powers amps down
// [R7] Gain codes 1 to 10, others unity
// [R8] Switch bit one closes, zero opens
// [R9] Software picks switch sets per measurement
// [R10] Reference DAC code scales half regulator
// [R11] Filter off powers comparator and PMOS down
// [R12] Software writes zero to filter bit 4
// [R13] Discharge bits one close, zero open
// [R14] Pattern RAM blocked while generator runs
// [R15] Pattern area bank 2, 40H to 7FH
// [R16] Software keeps sample counts within limits
// [R17] Fields hold last write, zero at reset
`timescale 1ns/10ps
module bio_impedance_frontend_ctrl (
   input wire logic clock_in,
   input wire logic rst_n_in,
   input wire logic hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic [31:0] hwdata_in,
   input wire logic hready_in,
   output logic [31:0] hrdata_out,
   output logic hreadyout_out,
   output logic hresp_out,
   input wire logic [1:0] cpu_ram_bank_in,
   input wire logic [7:0] cpu_ram_addr_in,
   input wire logic cpu_ram_req_in,
   output logic cpu_ram_grant_out,
   output logic sine_output_amp_pd_out,
   output logic sine_dac_pd_out,
   output logic bias_divider_pd_out,
   output logic [6:0] sine_n_out,
   output logic [5:0] half_cycle_samples_out,
   output logic first_amp_pd_out,
   output logic diff_amp_pd_out,
   output logic ref_dac_pd_out,
   output logic [3:0] diff_amp_gain_code_out,
   output logic [7:0] switch_close_out,
   output logic [5:0] ref_dac_code_out,
   output logic peak_comparator_pd_out,
   output logic pmos_pd_out,
   output logic [1:0] discharge_close_out
);
   // ==========================================================
   // Register storage, indexed by word address
   logic [7:0] regs_r [bio_frontend_pkg::NUM_REGS];
   logic [7:0] wmask [bio_frontend_pkg::NUM_REGS];
   assign wmask[0] = bio_frontend_pkg::MASK_SINE_GEN_CTRL;
   assign wmask[1] = bio_frontend_pkg::MASK_SINE_CLOCK_DIVISOR;
   assign wmask[2] = bio_frontend_pkg::MASK_HALF_WAVE_SAMPLE_COUNT;
   assign wmask[3] = bio_frontend_pkg::MASK_AMP_CTRL;
   assign wmask[4] = bio_frontend_pkg::MASK_ELECTRODE_SWITCH_CTRL;
   assign wmask[5] = bio_frontend_pkg::MASK_AMP_REF_DAC;
   assign wmask[6] = bio_frontend_pkg::MASK_PEAK_FILTER_CTRL;

   // ==========================================================
   // AHB-Lite address phase capture
   logic wr_pend_r;
   logic [2:0] wr_idx_r;
   logic wr_hit_r;
   wire addr_ok = hsel_in && hready_in && htrans_in[1];
   wire [2:0] a_idx = haddr_in[4:2];
   wire a_hit = (haddr_in[31:5] == 27'h0) && (haddr_in[1:0] == 2'h0) && (a_idx != 3'h7);
   wire a_stat = (haddr_in[31:8] == 24'h0) && (haddr_in[7:0] == bio_frontend_pkg::OFS_STATUS);

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wr_pend_r <= 1'b0;
         wr_idx_r <= 3'h0;
         wr_hit_r <= 1'b0;
      end else begin
         wr_pend_r <= addr_ok && hwrite_in;
         wr_idx_r <= a_idx;
         wr_hit_r <= a_hit;
      end
   end

   // Data phase write; bits outside the mask never stored
   genvar gi;
   generate
      for (gi = 0; gi < bio_frontend_pkg::NUM_REGS; gi++) begin : g_reg
         wire wr_this = wr_pend_r && wr_hit_r && (wr_idx_r == 3'(gi));
         wire [7:0] reg_nxt = wr_this ? (hwdata_in[7:0] & wmask[gi]) : regs_r[gi]; // R3 R17
         always_ff @(posedge clock_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               regs_r[gi] <= bio_frontend_pkg::REG_RESET; // R17
            end else begin
               regs_r[gi] <= reg_nxt;
            end
         end
      end
   endgenerate

   // ==========================================================
   // Read path: registered in address phase, zero wait state
   wire [7:0] stat_val = {6'h0, cpu_ram_grant_out, regs_r[0][7]};
   wire [7:0] rd_sel = a_stat ? stat_val : (a_hit ? regs_r[a_idx] : 8'h00); // R3
   // A read of a register written just before sees the new value
   wire fwd = wr_pend_r && wr_hit_r && a_hit && (wr_idx_r == a_idx);
   wire [7:0] rd_val = fwd ? (hwdata_in[7:0] & wmask[a_idx]) : rd_sel;

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         hrdata_out <= 32'h0;
         hreadyout_out <= 1'b1;
         hresp_out <= 1'b0;
      end else begin
         hrdata_out <= (addr_ok && !hwrite_in) ? {24'h0, rd_val} : 32'h0;
         hreadyout_out <= 1'b1;
         hresp_out <= 1'b0;
      end
   end

   // ==========================================================
   // Pattern RAM arbitration against the generator
   wire in_pattern = (cpu_ram_bank_in == bio_frontend_pkg::PATTERN_BANK) &&
                     (cpu_ram_addr_in >= bio_frontend_pkg::PATTERN_LO) &&
                     (cpu_ram_addr_in <= bio_frontend_pkg::PATTERN_HI); // R15
   wire grant_nxt = cpu_ram_req_in && !(in_pattern && regs_r[0][7]); // R14

   // ==========================================================
   // Decoded controls
   bio_frontend_pkg::analog_ctrl_t ctl;
   assign ctl.sine_gen_on = regs_r[0][7];
   assign ctl.bias_divider_on = regs_r[0][4];
   assign ctl.sine_n = {1'b0, regs_r[1][5:0]} + 7'h01; // R4
   assign ctl.half_cycle_samples = {1'b0, regs_r[2][4:0]} + 6'h01; // R5
   assign ctl.amp_power_off = regs_r[3][7];
   // Out-of-range codes collapse to code zero, which is unity gain
   assign ctl.diff_amp_gain_code = (regs_r[3][3:0] > bio_frontend_pkg::GAIN_CODE_MAX) ?
                                   4'h0 : regs_r[3][3:0]; // R7
   assign ctl.switches = regs_r[4];
   assign ctl.ref_dac_code = regs_r[5][5:0]; // R10
   assign ctl.peak_filter_on = regs_r[6][7];
   assign ctl.discharge = regs_r[6][1:0];

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cpu_ram_grant_out <= 1'b0;
         sine_output_amp_pd_out <= 1'b1;
         sine_dac_pd_out <= 1'b1;
         bias_divider_pd_out <= 1'b1;
         sine_n_out <= 7'h01;
         half_cycle_samples_out <= 6'h01;
         first_amp_pd_out <= 1'b0;
         diff_amp_pd_out <= 1'b0;
         ref_dac_pd_out <= 1'b0;
         diff_amp_gain_code_out <= 4'h0;
         switch_close_out <= 8'h00;
         ref_dac_code_out <= 6'h00;
         peak_comparator_pd_out <= 1'b1;
         pmos_pd_out <= 1'b1;
         discharge_close_out <= 2'h0;
      end else begin
         cpu_ram_grant_out <= grant_nxt;
         sine_output_amp_pd_out <= !ctl.sine_gen_on; // R1
         sine_dac_pd_out <= !ctl.sine_gen_on; // R1
         bias_divider_pd_out <= !ctl.bias_divider_on; // R2
         sine_n_out <= ctl.sine_n;
         half_cycle_samples_out <= ctl.half_cycle_samples;
         first_amp_pd_out <= ctl.amp_power_off; // R6
         diff_amp_pd_out <= ctl.amp_power_off; // R6
         ref_dac_pd_out <= ctl.amp_power_off; // R6
         diff_amp_gain_code_out <= ctl.diff_amp_gain_code;
         switch_close_out <= ctl.switches; // R8
         ref_dac_code_out <= ctl.ref_dac_code;
         peak_comparator_pd_out <= !ctl.peak_filter_on; // R11
         pmos_pd_out <= !ctl.peak_filter_on; // R11
         discharge_close_out <= ctl.discharge; // R13
      end
   end

   // ==========================================================
   // Checks
   a_sine_pd_follow: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R1
      !regs_r[0][7] |=> (sine_output_amp_pd_out && sine_dac_pd_out))
      else $error("sine power-down not following enable");
   a_bias_pd: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R2
      regs_r[0][4] |=> !bias_divider_pd_out)
      else $error("bias divider powered down while enabled");
   a_unimpl_zero: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R3
      (regs_r[0] & ~8'h90) == 8'h00 && (regs_r[6] & ~8'h83) == 8'h00 && regs_r[3][6:4] == 3'h0)
      else $error("unimplemented bit stored");
   a_divisor_n: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R4
      ##1 sine_n_out == {1'b0, $past(regs_r[1][5:0])} + 7'h01)
      else $error("divisor N not field plus one");
   a_half_count: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R5
      ##1 half_cycle_samples_out == {1'b0, $past(regs_r[2][4:0])} + 6'h01)
      else $error("half-cycle count not field plus one");
   a_amp_pd: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R6
      regs_r[3][7] |=> (first_amp_pd_out && diff_amp_pd_out && ref_dac_pd_out))
      else $error("amplifiers not powered down");
   a_gain_unity: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R7
      (regs_r[3][3:0] > 4'ha) |=> diff_amp_gain_code_out == 4'h0)
      else $error("invalid gain code not unity");
   a_switch_follow: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R8
      ##1 switch_close_out == $past(regs_r[4]))
      else $error("switch closures do not match register");
   a_filter_pd: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R11
      !regs_r[6][7] |=> (peak_comparator_pd_out && pmos_pd_out))
      else $error("filter not powered down");
   a_discharge: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R13
      ##1 discharge_close_out == $past(regs_r[6][1:0]))
      else $error("discharge switches wrong");
   a_ram_block: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R14
      (regs_r[0][7] && in_pattern) |=> !cpu_ram_grant_out)
      else $error("pattern RAM granted while generator on");
   a_write_store: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R17
      (wr_pend_r && wr_hit_r && wr_idx_r == 3'h4) |=> regs_r[4] == $past(hwdata_in[7:0]))
      else $error("write not stored");

   // ==========================================================
   // Power-down pairs, enabled states and the bias divider disabled state
   a_sine_pd_on: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R1
      regs_r[0][7] |=> (!sine_output_amp_pd_out && !sine_dac_pd_out))
      else $error("sine section powered down while enabled");

   a_sine_pd_pair: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R1
      sine_output_amp_pd_out == sine_dac_pd_out)
      else $error("sine amp and DAC power-down differ");

   a_bias_pd_off: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R2
      !regs_r[0][4] |=> bias_divider_pd_out)
      else $error("bias divider live while disabled");

   a_amp_pd_on: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R6
      !regs_r[3][7] |=> (!first_amp_pd_out && !diff_amp_pd_out && !ref_dac_pd_out))
      else $error("amplifiers powered down while enabled");

   a_amp_pd_pair: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R6
      first_amp_pd_out == diff_amp_pd_out && diff_amp_pd_out == ref_dac_pd_out)
      else $error("amplifier power-downs differ");

   a_filter_pd_on: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R11
      regs_r[6][7] |=> (!peak_comparator_pd_out && !pmos_pd_out))
      else $error("filter powered down while enabled");

   a_filter_pd_pair: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R11
      peak_comparator_pd_out == pmos_pd_out)
      else $error("comparator and PMOS power-down differ");

   // ==========================================================
   // Codes and counts
   a_gain_pass: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R7
      (regs_r[3][3:0] <= 4'ha) |=> diff_amp_gain_code_out == $past(regs_r[3][3:0]))
      else $error("valid gain code not passed");

   a_gain_range: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R7
      diff_amp_gain_code_out <= 4'ha)
      else $error("gain code out of range");

   a_ref_dac_follow: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R10
      ##1 ref_dac_code_out == $past(regs_r[5][5:0]))
      else $error("reference DAC code wrong");

   a_sine_n_range: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R4
      sine_n_out != 7'h00 && sine_n_out <= 7'h40)
      else $error("divisor N out of range");

   a_half_range: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R5
      half_cycle_samples_out != 6'h00 && half_cycle_samples_out <= 6'h20)
      else $error("half-cycle count out of range");

   // ==========================================================
   // Unimplemented bits
   a_divisor_unimpl: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R3
      regs_r[1][7:6] == 2'h0)
      else $error("divisor spare bits stored");

   a_count_unimpl: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R3
      regs_r[2][7:5] == 3'h0)
      else $error("count spare bits stored");

   a_dac_unimpl: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R3
      regs_r[5][7:6] == 2'h0)
      else $error("DAC spare bits stored");

   a_filter_spare: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R3
      regs_r[6][6:2] == 5'h0)
      else $error("filter spare bits stored");

   // ==========================================================
   // Pattern RAM arbitration
   a_ram_pass: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R14
      (cpu_ram_req_in && !in_pattern) |=> cpu_ram_grant_out)
      else $error("access outside pattern refused");

   a_ram_no_req: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R14
      !cpu_ram_req_in |=> !cpu_ram_grant_out)
      else $error("grant without request");

   a_ram_gen_off: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R14
      (cpu_ram_req_in && !regs_r[0][7]) |=> cpu_ram_grant_out)
      else $error("access refused with generator off");

   a_other_bank: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R15
      (cpu_ram_req_in && cpu_ram_bank_in != bio_frontend_pkg::PATTERN_BANK) |=> cpu_ram_grant_out)
      else $error("other bank refused");

   a_below_window: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R15
      (cpu_ram_req_in && cpu_ram_addr_in < 8'h40) |=> cpu_ram_grant_out)
      else $error("address below pattern refused");

   a_above_window: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R15
      (cpu_ram_req_in && cpu_ram_addr_in > 8'h7f) |=> cpu_ram_grant_out)
      else $error("address above pattern refused");

   // ==========================================================
   // Bus answers
   a_bus_ready: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R17
      hreadyout_out)
      else $error("wait state inserted");

   a_bus_okay: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R17
      !hresp_out)
      else $error("error response given");

   a_rdata_upper: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R3
      hrdata_out[31:8] == 24'h0)
      else $error("upper read bits not zero");

   a_rdata_idle: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R3
      !(addr_ok && !hwrite_in) |=> hrdata_out == 32'h0)
      else $error("read data outside read phase");

   a_read_value: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R17
      (addr_ok && !hwrite_in && a_hit && !fwd) |=> hrdata_out[7:0] == $past(regs_r[a_idx]))
      else $error("read value not register");

   a_read_forward: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R17
      (addr_ok && !hwrite_in && fwd) |=> hrdata_out[7:0] == $past(hwdata_in[7:0] & wmask[a_idx]))
      else $error("read after write stale");

   a_status_read: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R14
      (addr_ok && !hwrite_in && a_stat) |=>
      hrdata_out[7:0] == {6'h0, $past(cpu_ram_grant_out), $past(regs_r[0][7])})
      else $error("status read wrong");

   // Every register stores masked data and holds otherwise
   generate
      for (gi = 0; gi < bio_frontend_pkg::NUM_REGS; gi++) begin : g_chk
         a_reg_store: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R3
            (wr_pend_r && wr_hit_r && wr_idx_r == 3'(gi)) |=> regs_r[gi] == ($past(hwdata_in[7:0]) & wmask[gi]))
            else $error("masked write not stored");
         a_reg_hold: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R17
            !(wr_pend_r && wr_hit_r && wr_idx_r == 3'(gi)) |=> $stable(regs_r[gi]))
            else $error("register changed without write");
      end
   endgenerate
endmodule

// [tb/bio_analog_model.sv]
// Purpose: Behavioural stand-in for the analogue generator, amplifiers and filter
// Assumes: High on a power-down input means that circuit is off
// Notes: Reports which analogue sections are live, for the bench to compare
`timescale 1ns/10ps
module bio_analog_model (
   input wire logic sine_output_amp_pd_in,
   input wire logic sine_dac_pd_in,
   input wire logic bias_divider_pd_in,
   input wire logic first_amp_pd_in,
   input wire logic diff_amp_pd_in,
   input wire logic ref_dac_pd_in,
   input wire logic peak_comparator_pd_in,
   input wire logic pmos_pd_in,
   output logic [3:0] live_out
);
   // ==========================================================
   // A section runs only when every part of it is powered
   assign live_out[3] = !sine_output_amp_pd_in && !sine_dac_pd_in;
   assign live_out[2] = !bias_divider_pd_in;
   assign live_out[1] = !first_amp_pd_in && !diff_amp_pd_in && !ref_dac_pd_in;
   assign live_out[0] = !peak_comparator_pd_in && !pmos_pd_in;
endmodule

// [tb/bio_impedance_frontend_ctrl_test.sv]
// Purpose: Self-checking bench for the front-end register bank
// Assumes: Zero-wait AHB-Lite slave, outputs lag registers by one clock
// Notes: Register offsets step by one word from zero
`timescale 1ns/10ps
module bio_impedance_frontend_ctrl_test;
   logic clk, rst_n, hwrite, req, hready, hresp, grant;
   logic sopd, sdpd, bpd, apd1, apd2, rpd, cpd, ppd;
   logic [1:0] htrans, bank, dis;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [7:0] raddr, sw;
   logic [6:0] n;
   logic [5:0] half, dac;
   logic [3:0] gain, live;
   logic [7:0] masks [7] = '{8'h90, 8'h3f, 8'h1f, 8'h8f, 8'hff, 8'h3f, 8'h83};
   logic [10:0] ram [5] = '{{2'h2, 8'h40, 1'b0}, {2'h2, 8'h7f, 1'b0}, {2'h2, 8'h3f, 1'b1},
                            {2'h2, 8'h80, 1'b1}, {2'h1, 8'h50, 1'b1}};
   int bad_count, n_checks;
   wire [31:0] pds = {24'h0, sopd, sdpd, bpd, apd1, apd2, rpd, cpd, ppd};
   wire [31:0] codes = {3'h0, n, half, gain, dac, dis, live};
   bio_impedance_frontend_ctrl dut (.clock_in(clk), .rst_n_in(rst_n), .hsel_in(1'b1), .haddr_in(haddr),
      .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready),
      .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp), .cpu_ram_bank_in(bank),
      .cpu_ram_addr_in(raddr), .cpu_ram_req_in(req), .cpu_ram_grant_out(grant),
      .sine_output_amp_pd_out(sopd), .sine_dac_pd_out(sdpd), .bias_divider_pd_out(bpd), .sine_n_out(n),
      .half_cycle_samples_out(half), .first_amp_pd_out(apd1), .diff_amp_pd_out(apd2),
      .ref_dac_pd_out(rpd), .diff_amp_gain_code_out(gain), .switch_close_out(sw),
      .ref_dac_code_out(dac), .peak_comparator_pd_out(cpd), .pmos_pd_out(ppd), .discharge_close_out(dis));
   bio_analog_model far (.sine_output_amp_pd_in(sopd), .sine_dac_pd_in(sdpd), .bias_divider_pd_in(bpd),
      .first_amp_pd_in(apd1), .diff_amp_pd_in(apd2), .ref_dac_pd_in(rpd), .peak_comparator_pd_in(cpd),
      .pmos_pd_in(ppd), .live_out(live));
   // ==========================================================
   // Bus and compare tasks
   task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      q = hrdata;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
      bus(a, 1'b0, 32'h0);
      chk(q, exp);
      chk({31'h0, hresp}, 32'h0);
   endtask
   task automatic final_report;
      $display("mismatches %0d checks %0d", bad_count, n_checks);
      if (bad_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // Hang guard, far beyond the roughly 180 cycles the tests need
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      final_report;
   end
   // ==========================================================
   // Tests
   initial begin
      {rst_n, htrans, haddr, hwrite, hwdata, req, bank, raddr} = '0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      chk(pds, 32'he3);
      chk(codes, {3'h0, 7'h01, 6'h01, 4'h0, 6'h00, 2'h0, 4'h2});
      for (int i = 0; i < 7; i++) rdchk(32'(i * 4), 32'h0);
      for (int i = 0; i < 7; i++) begin
         bus(32'(i * 4), 1'b1, (i == 6) ? 32'hffffffef : 32'hffffffff);
         rdchk(32'(i * 4), {24'h0, masks[i]});
      end
      repeat (2) @(posedge clk);
      chk(pds, 32'h1c);
      chk(codes, {3'h0, 7'h40, 6'h20, 4'h0, 6'h3f, 2'h3, 4'b1101});
      chk({24'h0, sw}, 32'hff);
      bus(32'h18, 1'b1, 32'h0e);
      rdchk(32'h18, 32'h02);
      for (int g = 0; g < 16; g++) begin
         bus(32'h0c, 1'b1, 32'(g));
         repeat (2) @(posedge clk);
         chk({28'h0, gain}, (g <= 10) ? 32'(g) : 32'h0);
      end
      foreach (masks[i]) begin
         if (i < 3) begin
            bus(32'h10, 1'b1, {24'h0, (i == 0) ? 8'hc1 : (i == 1) ? 8'h32 : 8'h0e});
            repeat (2) @(posedge clk);
            chk({24'h0, sw}, {24'h0, (i == 0) ? 8'hc1 : (i == 1) ? 8'h32 : 8'h0e});
         end
      end
      foreach (ram[i]) begin
         {bank, raddr} <= ram[i][10:1];
         req <= 1'b1;
         repeat (2) @(posedge clk);
         chk({31'h0, grant}, {31'h0, ram[i][0]});
      end
      req <= 1'b0;
      repeat (2) @(posedge clk);
      chk({31'h0, grant}, 32'h0);
      rdchk(32'h1c, 32'h1);
      bus(32'h08, 1'b1, 32'h13);
      repeat (2) @(posedge clk);
      chk({26'h0, half}, 32'h14);
      bus(32'h20, 1'b1, 32'hffffffff);
      rdchk(32'h20, 32'h0);
      for (int i = 0; i < 7; i++) bus(32'(i * 4), 1'b1, 32'h0);
      {bank, raddr} <= 10'h250;
      req <= 1'b1;
      repeat (2) @(posedge clk);
      chk({31'h0, grant}, 32'h1);
      chk(pds, 32'he3);
      chk(codes, {3'h0, 7'h01, 6'h01, 4'h0, 6'h00, 2'h0, 4'h2});
      rdchk(32'h1c, 32'h2);
      final_report;
   end
endmodule
